// ==== pkg/wav_cfg.svh ====
// timing counts, field widths, program counter offsets and reset values for the weighted average sequencer
`ifndef WAV_CFG_SVH
`define WAV_CFG_SVH
`define WAV_OPND_W 8
`define WAV_NUM_W 24
`define WAV_DEN_W 16
`define WAV_TMP_W 16
`define WAV_SUM_W 32
`define WAV_ADDR_W 16
`define WAV_MUL_CYCLES 3
`define WAV_PC_RESUME_OFS 16'h0001
`define WAV_PC_NEXT_OFS 16'h0002
`define WAV_TMP_RESET 16'h0000
`endif

// ==== pkg/wav_pkg.sv ====
// types shared by the weighted average sequencer
package wav_pkg;
    typedef enum logic [4:0] {
        WAV_IDLE  = 5'h00,
        WAV_C1    = 5'h01,
        WAV_C2    = 5'h03,
        WAV_C3    = 5'h02,
        WAV_C4    = 5'h06,
        WAV_C5    = 5'h07,
        WAV_C6    = 5'h05,
        WAV_C7    = 5'h04,
        WAV_C8    = 5'h0C,
        WAV_C9    = 5'h0D,
        WAV_C10   = 5'h0F,
        WAV_PUSH  = 5'h0E,
        WAV_R1    = 5'h0A,
        WAV_R2    = 5'h0B,
        WAV_R3    = 5'h09,
        WAV_R4    = 5'h08,
        WAV_R5    = 5'h18
    } wav_state_e;
    typedef enum logic [1:0] {
        WAV_BUS_NONE  = 2'h0,
        WAV_BUS_READ  = 2'h1,
        WAV_BUS_WRITE = 2'h2
    } wav_bus_e;
endpackage

// ==== hdl/wav_mul.sv ====
// sequential 8x8 unsigned multiplier spread over three cycles
module wav_mul
    import wav_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    output logic [15:0] product,
    output logic done
);
`include "wav_cfg.svh"
    logic [15:0] acc_r, acc_nxt;
    logic [15:0] mcand_r, mcand_nxt;
    logic [7:0] mplier_r, mplier_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic done_r, done_nxt;
    // adds the multiplicand shifts picked by one group of three multiplier bits
    function automatic logic [15:0] add_group(input logic [15:0] acc, input logic [15:0] mc, input logic [2:0] sel);
        add_group = acc + (sel[0] ? mc : 16'h0000) + (sel[1] ? {mc[14:0], 1'b0} : 16'h0000)
            + (sel[2] ? {mc[13:0], 2'b00} : 16'h0000);
    endfunction
    // first group is added as the operands load, so the full product stands in the third cycle
    always_comb begin
        acc_nxt = acc_r;
        mcand_nxt = mcand_r;
        mplier_nxt = mplier_r;
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        if (start) begin
            acc_nxt = add_group(16'h0000, {8'h00, a}, b[2:0]);
            mcand_nxt = {5'b00000, a, 3'b000};
            mplier_nxt = {3'b000, b[7:3]};
            cnt_nxt = 2'(`WAV_MUL_CYCLES - 1);
        end else if (cnt_r != 2'h0) begin
            acc_nxt = add_group(acc_r, mcand_r, mplier_r[2:0]);
            mcand_nxt = {mcand_r[12:0], 3'b000};
            mplier_nxt = {3'b000, mplier_r[7:3]};
            cnt_nxt = cnt_r - 2'h1;
            done_nxt = (cnt_r == 2'h1);
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            acc_r <= 16'h0000;
            mcand_r <= 16'h0000;
            mplier_r <= 8'h00;
            cnt_r <= 2'h0;
            done_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            mcand_r <= mcand_nxt;
            mplier_r <= mplier_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end
    assign product = acc_r;
    assign done = done_r;
endmodule

// ==== hdl/wav_seq.sv ====
// weighted average execution sequencer with interrupt save and resume
// Summary of operation
// - operands are bytes; loop count comes from the 8-bit count accumulator
// - temporaries hold a 24-bit numerator and 16-bit denominator without loss
// - sums stay exact for any count from 1 to 255
// - cycle 1 fetches a program word only when the prebyte sits at odd address
// - normal start clears three 16-bit temporaries in cycle 2, no bus access
// - products sum in the high:low pair, weights in the third temporary
// - each loop pass takes seven cycles, numbered three to nine
// - count decrements in cycle 3; zero test after cycle 9 ends the loop
// - cycles 4 and 5 read both operands and advance each pointer
// - cycle 6 adds the fuzzy output into the weight sum
// - cycles 6 to 8 multiply output by singleton, cycle 9 adds into product sum
// - pending interrupt in a pass stacks temporaries then raises irq_take
// - interrupted exit sets program counter to the second opcode byte before stacking
// - resume opcode without prebyte enters the resume sequence, not the start
// - resume pops temporaries in 1.1 to 3.1, reads operands, rejoins at cycle 6
// - resume readjusts program counter so repeated interrupts behave identically
// - normal completion advances program counter past the instruction
// - completion moves product sum to output pointer and double accumulator, weights to singleton pointer
module wav_seq
    import wav_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic start_op,
    input wire logic start_resume,
    input wire logic prebyte_odd,
    input wire logic irq_pending,
    input wire logic [15:0] pc_in,
    input wire logic [15:0] singleton_ptr_in,
    input wire logic [15:0] output_ptr_in,
    input wire logic [7:0] count_in,
    input wire logic [15:0] sp_in,
    input wire logic [7:0] rd_byte,
    input wire logic [15:0] rd_word,
    output logic [1:0] bus_op,
    output logic bus_word,
    output logic bus_prog_fetch,
    output logic [15:0] bus_addr,
    output logic [15:0] bus_wdata,
    output logic busy,
    output logic done,
    output logic irq_take,
    output logic [15:0] pc_out,
    output logic [15:0] singleton_ptr_out,
    output logic [15:0] output_ptr_out,
    output logic [15:0] double_acc_out,
    output logic [7:0] count_out,
    output logic [15:0] sp_out
);
`include "wav_cfg.svh"
    wav_state_e state_r, state_nxt;
    logic [15:0] prod_hi_r, prod_hi_nxt;
    logic [15:0] prod_lo_r, prod_lo_nxt;
    logic [15:0] weight_r, weight_nxt;
    logic [15:0] xp_r, xp_nxt;
    logic [15:0] yp_r, yp_nxt;
    logic [15:0] dacc_r, dacc_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic [15:0] sp_r, sp_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [7:0] sing_r, sing_nxt;
    logic [7:0] fuzz_r, fuzz_nxt;
    logic [1:0] push_idx_r, push_idx_nxt;
    logic [1:0] bus_op_r, bus_op_nxt;
    logic bus_word_r, bus_word_nxt;
    logic fetch_r, fetch_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic [15:0] wdata_r, wdata_nxt;
    logic done_r, done_nxt;
    logic busy_r, busy_nxt;
    logic irq_take_r, irq_take_nxt;
    logic irq_sync1_r, irq_sync2_r;
    logic mul_start;
    logic [15:0] mul_product;
    logic mul_done;
    logic [31:0] prod_sum;

    // temporaries popped in the opposite order to the push
    function automatic logic [15:0] stack_slot(input logic [15:0] sp, input logic [1:0] idx);
        stack_slot = sp + {13'h0000, idx, 1'b0};
    endfunction

    wav_mul u_mul (
        .clk(clk),
        .reset(reset),
        .start(mul_start),
        .a(fuzz_r),
        .b(sing_r),
        .product(mul_product),
        .done(mul_done)
    );

    assign mul_start = (state_r == WAV_C6);
    assign prod_sum = {prod_hi_r, prod_lo_r} + {16'h0000, mul_product};

    always_comb begin
        state_nxt = state_r;
        prod_hi_nxt = prod_hi_r;
        prod_lo_nxt = prod_lo_r;
        weight_nxt = weight_r;
        xp_nxt = xp_r;
        yp_nxt = yp_r;
        dacc_nxt = dacc_r;
        pc_nxt = pc_r;
        sp_nxt = sp_r;
        cnt_nxt = cnt_r;
        sing_nxt = sing_r;
        fuzz_nxt = fuzz_r;
        push_idx_nxt = push_idx_r;
        bus_op_nxt = WAV_BUS_NONE;
        bus_word_nxt = 1'b0;
        fetch_nxt = 1'b0;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        done_nxt = 1'b0;
        irq_take_nxt = 1'b0;
        case (state_r)
            WAV_IDLE: begin
                // resume has priority: it carries partial sums that must not be discarded
                if (start_resume) begin
                    xp_nxt = singleton_ptr_in;
                    yp_nxt = output_ptr_in;
                    cnt_nxt = count_in;
                    sp_nxt = sp_in;
                    pc_nxt = pc_in - `WAV_PC_RESUME_OFS;
                    push_idx_nxt = 2'h0;
                    bus_op_nxt = WAV_BUS_READ;
                    bus_word_nxt = 1'b1;
                    addr_nxt = sp_in;
                    state_nxt = WAV_R1;
                end else if (start_op) begin
                    xp_nxt = singleton_ptr_in;
                    yp_nxt = output_ptr_in;
                    cnt_nxt = count_in;
                    sp_nxt = sp_in;
                    pc_nxt = pc_in;
                    if (prebyte_odd) begin
                        bus_op_nxt = WAV_BUS_READ;
                        bus_word_nxt = 1'b1;
                        fetch_nxt = 1'b1;
                        addr_nxt = pc_in + `WAV_PC_NEXT_OFS;
                    end
                    state_nxt = WAV_C1;
                end
            end
            WAV_C1: begin
                state_nxt = WAV_C2;
            end
            WAV_C2: begin
                prod_hi_nxt = `WAV_TMP_RESET;
                prod_lo_nxt = `WAV_TMP_RESET;
                weight_nxt = `WAV_TMP_RESET;
                state_nxt = WAV_C3;
            end
            WAV_C3: begin
                cnt_nxt = cnt_r - 8'h01;
                bus_op_nxt = WAV_BUS_READ;
                addr_nxt = xp_r;
                state_nxt = WAV_C4;
            end
            WAV_C4: begin
                sing_nxt = rd_byte;
                xp_nxt = xp_r + 16'h0001;
                bus_op_nxt = WAV_BUS_READ;
                addr_nxt = yp_r;
                state_nxt = WAV_C5;
            end
            WAV_C5: begin
                fuzz_nxt = rd_byte;
                yp_nxt = yp_r + 16'h0001;
                if (irq_sync2_r) begin
                    // undo this pass so resume rereads the same operands
                    xp_nxt = xp_r - 16'h0001;
                    yp_nxt = yp_r;
                    cnt_nxt = cnt_r + 8'h01;
                    pc_nxt = pc_r + `WAV_PC_RESUME_OFS;
                    push_idx_nxt = 2'h0;
                    state_nxt = WAV_PUSH;
                end else begin
                    state_nxt = WAV_C6;
                end
            end
            WAV_C6: begin
                weight_nxt = weight_r + {8'h00, fuzz_r};
                state_nxt = WAV_C7;
            end
            WAV_C7: begin
                state_nxt = WAV_C8;
            end
            WAV_C8: begin
                state_nxt = WAV_C9;
            end
            WAV_C9: begin
                {prod_hi_nxt, prod_lo_nxt} = mul_done ? prod_sum : {prod_hi_r, prod_lo_r};
                state_nxt = (cnt_r == 8'h00) ? WAV_C10 : WAV_C3;
            end
            WAV_C10: begin
                pc_nxt = pc_r + `WAV_PC_NEXT_OFS;
                yp_nxt = prod_hi_r;
                dacc_nxt = prod_lo_r;
                xp_nxt = weight_r;
                done_nxt = 1'b1;
                state_nxt = WAV_IDLE;
            end
            WAV_PUSH: begin
                // weight sum, then low, then high: high ends nearest the new stack top
                bus_op_nxt = WAV_BUS_WRITE;
                bus_word_nxt = 1'b1;
                sp_nxt = sp_r - 16'h0002;
                addr_nxt = sp_r - 16'h0002;
                case (push_idx_r)
                    2'h0: wdata_nxt = weight_r;
                    2'h1: wdata_nxt = prod_lo_r;
                    default: wdata_nxt = prod_hi_r;
                endcase
                push_idx_nxt = push_idx_r + 2'h1;
                if (push_idx_r == 2'h2) begin
                    irq_take_nxt = 1'b1;
                    state_nxt = WAV_IDLE;
                end
            end
            WAV_R1: begin
                prod_hi_nxt = rd_word;
                bus_op_nxt = WAV_BUS_READ;
                bus_word_nxt = 1'b1;
                addr_nxt = stack_slot(sp_r, 2'h1);
                state_nxt = WAV_R2;
            end
            WAV_R2: begin
                prod_lo_nxt = rd_word;
                bus_op_nxt = WAV_BUS_READ;
                bus_word_nxt = 1'b1;
                addr_nxt = stack_slot(sp_r, 2'h2);
                state_nxt = WAV_R3;
            end
            WAV_R3: begin
                weight_nxt = rd_word;
                sp_nxt = stack_slot(sp_r, 2'h3);
                cnt_nxt = cnt_r - 8'h01;
                bus_op_nxt = WAV_BUS_READ;
                addr_nxt = xp_r;
                state_nxt = WAV_R4;
            end
            WAV_R4: begin
                sing_nxt = rd_byte;
                xp_nxt = xp_r + 16'h0001;
                bus_op_nxt = WAV_BUS_READ;
                addr_nxt = yp_r;
                state_nxt = WAV_R5;
            end
            WAV_R5: begin
                fuzz_nxt = rd_byte;
                yp_nxt = yp_r + 16'h0001;
                state_nxt = WAV_C6;
            end
            default: begin
                state_nxt = WAV_IDLE;
            end
        endcase
        busy_nxt = (state_nxt != WAV_IDLE);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= WAV_IDLE;
            prod_hi_r <= `WAV_TMP_RESET;
            prod_lo_r <= `WAV_TMP_RESET;
            weight_r <= `WAV_TMP_RESET;
            xp_r <= 16'h0000;
            yp_r <= 16'h0000;
            dacc_r <= 16'h0000;
            pc_r <= 16'h0000;
            sp_r <= 16'h0000;
            cnt_r <= 8'h00;
            sing_r <= 8'h00;
            fuzz_r <= 8'h00;
            push_idx_r <= 2'h0;
            bus_op_r <= WAV_BUS_NONE;
            bus_word_r <= 1'b0;
            fetch_r <= 1'b0;
            addr_r <= 16'h0000;
            wdata_r <= 16'h0000;
            done_r <= 1'b0;
            irq_take_r <= 1'b0;
            busy_r <= 1'b0;
            irq_sync1_r <= 1'b0;
            irq_sync2_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            prod_hi_r <= prod_hi_nxt;
            prod_lo_r <= prod_lo_nxt;
            weight_r <= weight_nxt;
            xp_r <= xp_nxt;
            yp_r <= yp_nxt;
            dacc_r <= dacc_nxt;
            pc_r <= pc_nxt;
            sp_r <= sp_nxt;
            cnt_r <= cnt_nxt;
            sing_r <= sing_nxt;
            fuzz_r <= fuzz_nxt;
            push_idx_r <= push_idx_nxt;
            bus_op_r <= bus_op_nxt;
            bus_word_r <= bus_word_nxt;
            fetch_r <= fetch_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            done_r <= done_nxt;
            irq_take_r <= irq_take_nxt;
            busy_r <= busy_nxt;
            irq_sync1_r <= irq_pending;
            irq_sync2_r <= irq_sync1_r;
        end
    end

    assign bus_op = bus_op_r;
    assign bus_word = bus_word_r;
    assign bus_prog_fetch = fetch_r;
    assign bus_addr = addr_r;
    assign bus_wdata = wdata_r;
    assign busy = busy_r;
    assign done = done_r;
    assign irq_take = irq_take_r;
    assign pc_out = pc_r;
    assign singleton_ptr_out = xp_r;
    assign output_ptr_out = yp_r;
    assign double_acc_out = dacc_r;
    assign count_out = cnt_r;
    assign sp_out = sp_r;
endmodule

// ==== verification/wseq_asserts.sv ====
// concurrent checks on the weighted average sequencer ports
module wseq_asserts
    import wav_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic start_op,
    input wire logic start_resume,
    input wire logic prebyte_odd,
    input wire logic [15:0] pc_in,
    input wire logic [7:0] count_in,
    input wire logic [15:0] sp_in,
    input wire logic [1:0] bus_op,
    input wire logic bus_prog_fetch,
    input wire logic busy,
    input wire logic done,
    input wire logic irq_take,
    input wire logic [15:0] pc_out,
    input wire logic [15:0] sp_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic take;
    logic res_r, res_nxt;
    logic [15:0] pc_r, pc_nxt, sp_r, sp_nxt, cnt_r, cnt_nxt;
    logic [8:0] n_r, n_nxt;
    assign take = !busy && (start_op || start_resume);
    // captured at the taking edge so results can be tied back to what was started
    always_comb begin
        res_nxt = take ? start_resume : res_r;
        pc_nxt = take ? pc_in : pc_r;
        sp_nxt = take ? sp_in : sp_r;
        n_nxt = take ? ((count_in == 8'h00) ? 9'h100 : {1'b0, count_in}) : n_r;
        cnt_nxt = take ? 16'h0000 : cnt_r + 16'h0001;
    end
    always_ff @(posedge clk) begin
        res_r <= reset ? 1'b0 : res_nxt;
        pc_r <= reset ? 16'h0000 : pc_nxt;
        sp_r <= reset ? 16'h0000 : sp_nxt;
        n_r <= reset ? 9'h000 : n_nxt;
        cnt_r <= reset ? 16'h0000 : cnt_nxt;
    end
    a_start_busy: assert property (take |=> busy)
        else $error("busy did not follow a taken start");
    a_even_quiet: assert property (take && !start_resume && !prebyte_odd |=> bus_op == WAV_BUS_NONE)
        else $error("bus access in first cycle with even prebyte");
    a_odd_fetch: assert property (take && !start_resume && prebyte_odd |=> bus_op == WAV_BUS_READ && bus_prog_fetch)
        else $error("no program fetch in first cycle with odd prebyte");
    a_clear_quiet: assert property (take && !start_resume |=> ##1 bus_op == WAV_BUS_NONE)
        else $error("bus access in the clearing cycle");
    a_loop_time: assert property (done && !res_r |-> cnt_r == 16'h0003 + 16'h0007 * {7'h00, n_r})
        else $error("normal run length wrong");
    a_no_early: assert property (take && !start_resume |=> !done [*8])
        else $error("completion before the first pass could end");
    a_done_pc: assert property (done |-> pc_out == pc_r + (res_r ? 16'h0001 : 16'h0002))
        else $error("program counter not past the instruction");
    a_irq_pc: assert property (irq_take |-> pc_out == pc_r + (res_r ? 16'h0000 : 16'h0001))
        else $error("stacked program counter not at the resume byte");
    a_irq_stack: assert property (irq_take |-> sp_out == sp_r - (res_r ? 16'h0000 : 16'h0006))
        else $error("stack pointer wrong after saving temporaries");
    a_done_pulse: assert property (done |=> !done && !irq_take)
        else $error("completion pulse longer than one cycle");
endmodule

bind wav_seq wseq_asserts u_chk (.clk(clk), .reset(reset), .start_op(start_op), .start_resume(start_resume),
    .prebyte_odd(prebyte_odd), .pc_in(pc_in), .count_in(count_in), .sp_in(sp_in), .bus_op(bus_op),
    .bus_prog_fetch(bus_prog_fetch), .busy(busy), .done(done), .irq_take(irq_take), .pc_out(pc_out),
    .sp_out(sp_out));

// ==== verification/wseq_mem_model.sv ====
// byte memory answering the sequencer bus, words stored high byte first
module wseq_mem_model
    import wav_pkg::*;
(
    input wire logic clk,
    input wire logic [1:0] bus_op,
    input wire logic bus_word,
    input wire logic [15:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    output logic [7:0] rd_byte,
    output logic [15:0] rd_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'h5A ^ i[7:0];
    end
    // data returns in the cycle the read stands; inverted otherwise so a stray sample shows
    assign rd_byte = (bus_op == WAV_BUS_READ) ? mem[bus_addr] : ~mem[bus_addr];
    assign rd_word = (bus_op == WAV_BUS_READ) ? {mem[bus_addr], mem[bus_addr + 16'h0001]}
        : ~{mem[bus_addr], mem[bus_addr + 16'h0001]};
    always @(posedge clk) begin
        if (bus_op == WAV_BUS_WRITE && bus_word) begin
            mem[bus_addr] <= bus_wdata[15:8];
            mem[bus_addr + 16'h0001] <= bus_wdata[7:0];
        end else if (bus_op == WAV_BUS_WRITE) begin
            mem[bus_addr] <= bus_wdata[7:0];
        end
    end
endmodule

// ==== verification/weighted_average_sequencer_bench.sv ====
// self-checking bench for the weighted average sequencer
module weighted_average_sequencer_bench import wav_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, start_op, start_resume, prebyte_odd, irq_pending, bus_word, bus_prog_fetch, busy, done, irq_take;
    logic [15:0] pc_in, singleton_ptr_in, output_ptr_in, sp_in, bus_addr, bus_wdata, rd_word;
    logic [15:0] pc_out, singleton_ptr_out, output_ptr_out, double_acc_out, sp_out;
    logic [7:0] count_in, rd_byte, count_out;
    logic [1:0] bus_op;
    int error_cnt = 0;
    int total_checks = 0;
    wav_seq dut (.clk(clk), .reset(reset), .start_op(start_op), .start_resume(start_resume),
        .prebyte_odd(prebyte_odd), .irq_pending(irq_pending), .pc_in(pc_in), .singleton_ptr_in(singleton_ptr_in),
        .output_ptr_in(output_ptr_in), .count_in(count_in), .sp_in(sp_in), .rd_byte(rd_byte), .rd_word(rd_word),
        .bus_op(bus_op), .bus_word(bus_word), .bus_prog_fetch(bus_prog_fetch), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .busy(busy), .done(done), .irq_take(irq_take), .pc_out(pc_out),
        .singleton_ptr_out(singleton_ptr_out), .output_ptr_out(output_ptr_out), .double_acc_out(double_acc_out),
        .count_out(count_out), .sp_out(sp_out));
    wseq_mem_model mdl (.clk(clk), .bus_op(bus_op), .bus_word(bus_word), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .rd_byte(rd_byte), .rd_word(rd_word));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // operand tables and the sums they should give
    task automatic fill(input logic [15:0] sx, sy, input int n, input logic [7:0] s0, ds, f0, df,
        output logic [31:0] p, output logic [15:0] w);
        logic [7:0] s, f;
        p = 32'h00000000;
        w = 16'h0000;
        s = s0;
        f = f0;
        for (int i = 0; i < n; i++) begin
            mdl.mem[sx + i[15:0]] = s;
            mdl.mem[sy + i[15:0]] = f;
            p = p + {24'h000000, s} * {24'h000000, f};
            w = w + {8'h00, f};
            s = s + ds;
            f = f + df;
        end
    endtask
    // cyc counts cycles after the taking edge until done or irq_take shows
    task automatic op(input logic res, odd, input logic [15:0] pc, sx, sy, sp, input logic [7:0] n, output int cyc);
        @(negedge clk);
        start_op = !res;
        start_resume = res;
        prebyte_odd = odd;
        pc_in = pc;
        singleton_ptr_in = sx;
        output_ptr_in = sy;
        sp_in = sp;
        count_in = n;
        @(negedge clk);
        start_op = 1'b0;
        start_resume = 1'b0;
        for (cyc = 0; cyc < 3000; cyc++) begin
            if (done === 1'b1 || irq_take === 1'b1) return;
            @(negedge clk);
        end
        error_cnt++;
        $display("[FAIL] %0t operation never finished", $time);
        give_verdict();
    endtask
    task automatic chk_done(input logic [31:0] p, input logic [15:0] w, pc);
        check(done, 1'b1);
        check({output_ptr_out, double_acc_out}, p);
        check(singleton_ptr_out, w);
        check(pc_out, pc + 16'h0002);
    endtask
    task automatic t_basic();
        logic [31:0] p;
        logic [15:0] w;
        int c;
        fill(16'h1000, 16'h2000, 3, 8'h11, 8'h22, 8'h90, 8'h10, p, w);
        op(1'b0, 1'b0, 16'h4000, 16'h1000, 16'h2000, 16'h8000, 8'h03, c);
        check(c, 32'd24);
        chk_done(p, w, 16'h4000);
        check(count_out, 8'h00);
    endtask
    task automatic t_odd();
        logic [31:0] p;
        logic [15:0] w;
        int c;
        fill(16'h1100, 16'h2100, 1, 8'hC3, 8'h00, 8'h7E, 8'h00, p, w);
        op(1'b0, 1'b1, 16'h4101, 16'h1100, 16'h2100, 16'h8000, 8'h01, c);
        check(c, 32'd10);
        chk_done(p, w, 16'h4101);
    endtask
    // largest count with all-ones operands: carries must reach the high half
    task automatic t_max();
        logic [31:0] p;
        logic [15:0] w;
        int c;
        fill(16'h1200, 16'h2400, 255, 8'hFF, 8'h00, 8'hFF, 8'h00, p, w);
        op(1'b0, 1'b0, 16'h4200, 16'h1200, 16'h2400, 16'h8000, 8'hFF, c);
        check(c, 32'd1788);
        chk_done(p, w, 16'h4200);
    endtask
    // interrupted, a nested run in the handler, interrupted again, then finished
    task automatic t_irq();
        logic [31:0] p, p2;
        logic [15:0] w, w2, rpc, rsx, rsy, rsp;
        logic [7:0] rn;
        int c;
        fill(16'h3000, 16'h3100, 6, 8'h05, 8'h0B, 8'h40, 8'hF3, p, w);
        irq_pending = 1'b1;
        op(1'b0, 1'b0, 16'h5000, 16'h3000, 16'h3100, 16'h9000, 8'h06, c);
        check(irq_take, 1'b1);
        check(pc_out, 16'h5001);
        check(sp_out, 16'h8FFA);
        {rpc, rsx, rsy, rsp, rn} = {pc_out, singleton_ptr_out, output_ptr_out, sp_out, count_out};
        irq_pending = 1'b0;
        fill(16'h3400, 16'h3500, 2, 8'hA0, 8'h01, 8'h33, 8'h44, p2, w2);
        op(1'b0, 1'b1, 16'h6001, 16'h3400, 16'h3500, rsp, 8'h02, c);
        chk_done(p2, w2, 16'h6001);
        irq_pending = 1'b1;
        op(1'b1, 1'b0, rpc, rsx, rsy, rsp, rn, c);
        check(irq_take, 1'b1);
        check(pc_out, rpc);
        check(sp_out, rsp);
        {rpc, rsx, rsy, rsp, rn} = {pc_out, singleton_ptr_out, output_ptr_out, sp_out, count_out};
        irq_pending = 1'b0;
        op(1'b1, 1'b0, rpc, rsx, rsy, rsp, rn, c);
        chk_done(p, w, 16'h5000);
    endtask
    initial begin
        {reset, start_op, start_resume, prebyte_odd, irq_pending} = 5'h10;
        {pc_in, singleton_ptr_in, output_ptr_in, sp_in, count_in} = 72'h0;
        repeat (20) @(negedge clk);
        reset = 1'b0;
        t_basic();
        t_odd();
        t_max();
        t_irq();
        give_verdict();
    end
endmodule
